// ### logic/sysctl_regs.sv
// system control and protection unit register bank with access checker
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module sysctl_regs (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire sysctl_pkg::access_req_t access,
   input wire sysctl_pkg::region_t [7:0] regions,
   output logic access_fault,
   output logic unaligned_fault,
   input wire logic exc_entry,
   input wire logic exc_return,
   input wire logic sp_misaligned,
   input wire logic [31:0] stacked_status_in,
   output logic [31:0] stacked_status_out,
   output logic sp_realign,
   input wire logic svc_pend_set,
   input wire logic svc_pend_clr,
   output logic svc_pending,
   output logic [1:0] supervisor_call_priority,
   output logic [1:0] tick_exception_priority,
   output logic [1:0] pendable_service_priority,
   output sysctl_pkg::prot_ctrl_t prot_ctrl,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////
   // bus decode
   sysctl_pkg::apb_state_t state; // slave phase tracker
   logic wr_en; // write takes effect this edge
   logic [15:0] addr_lo; // offset part of address
   logic hit; // address maps to a register
   logic [31:0] next_rdata; // read mux output
   logic [sysctl_pkg::NUM_EVENTS-1:0] event_status; // sticky events
   logic [sysctl_pkg::NUM_EVENTS-1:0] event_enable; // interrupt mask
   logic [sysctl_pkg::NUM_EVENTS-1:0] event_pulse; // raw events
   logic [sysctl_pkg::NUM_EVENTS-1:0] event_clear; // clear strobes
   logic next_access_fault; // checker result
   logic next_unaligned; // alignment result

   assign addr_lo = paddr[15:0];
   // a write lands only in an access phase that followed its own setup cycle
   assign wr_en = psel && penable && pwrite && (state == sysctl_pkg::ST_ACCESS);
   assign pready = 1'b1; // zero wait states

   // phase tracker, keeps a stray penable without setup from writing
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state <= sysctl_pkg::ST_IDLE;
      end else begin
         case (state)
            sysctl_pkg::ST_IDLE: begin
               if (psel && !penable) begin
                  state <= sysctl_pkg::ST_ACCESS;
               end
            end
            sysctl_pkg::ST_ACCESS: begin
               state <= sysctl_pkg::ST_IDLE;
            end
            default: begin
               state <= sysctl_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // address hit detection for error answer
   always_comb begin
      case (addr_lo)
         sysctl_pkg::ADDR_CONFIG_CONTROL,
         sysctl_pkg::ADDR_HANDLER_PRIORITY_TWO,
         sysctl_pkg::ADDR_HANDLER_PRIORITY_THREE,
         sysctl_pkg::ADDR_HANDLER_CONTROL_STATE,
         sysctl_pkg::ADDR_PROTECTION_UNIT_TYPE,
         sysctl_pkg::ADDR_PROTECTION_UNIT_CONTROL,
         sysctl_pkg::ADDR_EVENT_STATUS,
         sysctl_pkg::ADDR_EVENT_ENABLE,
         sysctl_pkg::ADDR_EVENT_CLEAR: hit = (paddr[31:16] == 16'he000);
         default: hit = 1'b0;
      endcase
   end
   // unmapped address answers error in access phase
   assign pslverr = psel && penable && !hit;

   ////////////////////////////////////////////////////////////////////////
   // writable priority fields
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         supervisor_call_priority <= sysctl_pkg::PRIO_RESET;
         tick_exception_priority <= sysctl_pkg::PRIO_RESET;
         pendable_service_priority <= sysctl_pkg::PRIO_RESET;
      end else if (wr_en && hit) begin
         if (addr_lo == sysctl_pkg::ADDR_HANDLER_PRIORITY_TWO) begin
            supervisor_call_priority <= pwdata[sysctl_pkg::PRIO_HI_LSB +: 2];
         end
         if (addr_lo == sysctl_pkg::ADDR_HANDLER_PRIORITY_THREE) begin
            tick_exception_priority <= pwdata[sysctl_pkg::PRIO_HI_LSB +: 2];
            pendable_service_priority <= pwdata[sysctl_pkg::PENDABLE_SERVICE_EXCEPTION_PRIO_LSB +: 2];
         end
      end
   end

   // supervisor call pending flag; core set wins over bus clear
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         svc_pending <= 1'b0;
      end else if (svc_pend_set) begin
         svc_pending <= 1'b1;
      end else if (wr_en && hit && addr_lo == sysctl_pkg::ADDR_HANDLER_CONTROL_STATE) begin
         svc_pending <= pwdata[sysctl_pkg::SVC_PENDING_BIT];
      end else if (svc_pend_clr) begin
         svc_pending <= 1'b0;
      end
   end

   // protection unit control word
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         prot_ctrl <= sysctl_pkg::CTRL_RESET;
      end else if (wr_en && hit && addr_lo == sysctl_pkg::ADDR_PROTECTION_UNIT_CONTROL) begin
         prot_ctrl.enable <= pwdata[sysctl_pkg::CTRL_ENABLE_BIT];
         prot_ctrl.fault_handler_protection_enable <= pwdata[sysctl_pkg::CTRL_HFNMI_BIT];
         prot_ctrl.privileged_background_enable <= pwdata[sysctl_pkg::CTRL_PRIVDEF_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data mux, reserved bits zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (addr_lo)
         sysctl_pkg::ADDR_CONFIG_CONTROL: begin
            next_rdata[sysctl_pkg::STACK_ALIGN_BIT] = 1'b1;
            next_rdata[sysctl_pkg::UNALIGNED_TRAP_BIT] = 1'b1;
         end
         sysctl_pkg::ADDR_HANDLER_PRIORITY_TWO: begin
            next_rdata[sysctl_pkg::PRIO_HI_LSB +: 2] = supervisor_call_priority;
         end
         sysctl_pkg::ADDR_HANDLER_PRIORITY_THREE: begin
            next_rdata[sysctl_pkg::PRIO_HI_LSB +: 2] = tick_exception_priority;
            next_rdata[sysctl_pkg::PENDABLE_SERVICE_EXCEPTION_PRIO_LSB +: 2] = pendable_service_priority;
         end
         sysctl_pkg::ADDR_HANDLER_CONTROL_STATE: begin
            next_rdata[sysctl_pkg::SVC_PENDING_BIT] = svc_pending;
         end
         sysctl_pkg::ADDR_PROTECTION_UNIT_TYPE: begin
            next_rdata[23:16] = sysctl_pkg::INSTR_REGION_COUNT;
            next_rdata[sysctl_pkg::DATA_REGION_LSB +: 8] = sysctl_pkg::DATA_REGION_COUNT;
         end
         sysctl_pkg::ADDR_PROTECTION_UNIT_CONTROL: begin
            next_rdata[2:0] = prot_ctrl;
         end
         sysctl_pkg::ADDR_EVENT_STATUS: begin
            next_rdata[sysctl_pkg::NUM_EVENTS-1:0] = event_status;
         end
         sysctl_pkg::ADDR_EVENT_ENABLE: begin
            next_rdata[sysctl_pkg::NUM_EVENTS-1:0] = event_enable;
         end
         default: begin
            next_rdata = 32'h0000_0000; // clear register and unmapped read zero
         end
      endcase
      if (!hit) begin
         next_rdata = 32'h0000_0000;
      end
   end

   // read data comes from a flop, loaded in setup phase
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // stacked status alignment bit
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         stacked_status_out <= 32'h0000_0000;
         sp_realign <= 1'b0;
      end else begin
         if (exc_entry) begin
            stacked_status_out <= stacked_status_in;
            stacked_status_out[sysctl_pkg::STACKED_ALIGN_BIT] <= sp_misaligned;
         end
         if (exc_return) begin
            sp_realign <= stacked_status_in[sysctl_pkg::STACKED_ALIGN_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // access checker
   always_comb begin
      logic covered;
      logic [31:0] mask;
      covered = 1'b0;
      mask = 32'h0000_0000;
      next_unaligned = 1'b0;
      // unaligned access of size 1 or 2 always faults; sizes 0 and 3 never fault
      case (access.size)
         2'h1: next_unaligned = access.valid && access.addr[0];
         2'h2: next_unaligned = access.valid && (access.addr[1:0] != 2'h0);
         default: next_unaligned = 1'b0;
      endcase
      // any enabled region covering the address overrides background
      for (int i = 0; i < sysctl_pkg::NUM_REGIONS; i++) begin
         mask = ~((32'h0000_0002 << regions[i].size) - 32'h0000_0001);
         if (regions[i].enable && ((access.addr & mask) == (regions[i].base & mask))) begin
            covered = 1'b1;
         end
      end
      if (!access.valid || !prot_ctrl.enable) begin
         next_access_fault = 1'b0;
      end else if (access.in_fault_handler && !prot_ctrl.fault_handler_protection_enable) begin
         next_access_fault = 1'b0;
      end else if (covered) begin
         next_access_fault = 1'b0;
      end else if (prot_ctrl.privileged_background_enable && access.privileged) begin
         next_access_fault = 1'b0;
      end else begin
         next_access_fault = 1'b1;
      end
   end

   // registered fault outputs
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         access_fault <= 1'b0;
         unaligned_fault <= 1'b0;
      end else begin
         access_fault <= next_access_fault;
         unaligned_fault <= next_unaligned;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // event status, enable, interrupt
   assign event_pulse[sysctl_pkg::EV_UNALIGNED] = unaligned_fault;
   assign event_pulse[sysctl_pkg::EV_PROT_FAULT] = access_fault;
   assign event_pulse[sysctl_pkg::EV_SVC_PEND] = svc_pend_set;

   // enable register
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         event_enable <= '0;
      end else if (wr_en && hit && addr_lo == sysctl_pkg::ADDR_EVENT_ENABLE) begin
         event_enable <= pwdata[sysctl_pkg::NUM_EVENTS-1:0];
      end
   end

   // sticky bits, set wins over clear
   genvar g;
   generate
      for (g = 0; g < sysctl_pkg::NUM_EVENTS; g++) begin : g_ev
         assign event_clear[g] = wr_en && hit && (addr_lo == sysctl_pkg::ADDR_EVENT_CLEAR) && pwdata[g];
         always_ff @(posedge mclk) begin
            if (sys_rst) begin
               event_status[g] <= 1'b0;
            end else if (event_pulse[g]) begin
               event_status[g] <= 1'b1;
            end else if (event_clear[g]) begin
               event_status[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // level interrupt
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(event_status & event_enable);
      end
   end
endmodule
`default_nettype wire

// ### logic/sysctl_pkg.sv
// package of offsets, fields and types for the system control register bank
`default_nettype none
package sysctl_pkg;
   // byte addresses of the registers
   localparam logic [15:0] ADDR_CONFIG_CONTROL = 16'hed14;
   localparam logic [15:0] ADDR_HANDLER_PRIORITY_TWO = 16'hed1c;
   localparam logic [15:0] ADDR_HANDLER_PRIORITY_THREE = 16'hed20;
   localparam logic [15:0] ADDR_HANDLER_CONTROL_STATE = 16'hed24;
   localparam logic [15:0] ADDR_PROTECTION_UNIT_TYPE = 16'hed90;
   localparam logic [15:0] ADDR_PROTECTION_UNIT_CONTROL = 16'hed94;
   localparam logic [15:0] ADDR_EVENT_STATUS = 16'hedf0;
   localparam logic [15:0] ADDR_EVENT_ENABLE = 16'hedf4;
   localparam logic [15:0] ADDR_EVENT_CLEAR = 16'hedf8;
   // field positions
   localparam int STACK_ALIGN_BIT = 9;
   localparam int UNALIGNED_TRAP_BIT = 3;
   localparam int PRIO_HI_LSB = 30;
   localparam int PENDABLE_SERVICE_EXCEPTION_PRIO_LSB = 22;
   localparam int SVC_PENDING_BIT = 15;
   localparam int DATA_REGION_LSB = 8;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_HFNMI_BIT = 1;
   localparam int CTRL_PRIVDEF_BIT = 2;
   localparam int STACKED_ALIGN_BIT = 9;
   // constant values
   localparam logic [7:0] DATA_REGION_COUNT = 8'h08;
   localparam logic [7:0] INSTR_REGION_COUNT = 8'h00;
   localparam int NUM_REGIONS = 8;
   localparam logic [1:0] PRIO_RESET = 2'h0;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam int NUM_EVENTS = 3;
   // event bit positions
   localparam int EV_UNALIGNED = 0;
   localparam int EV_PROT_FAULT = 1;
   localparam int EV_SVC_PEND = 2;
   // protection unit control fields
   typedef struct packed {
      logic privileged_background_enable;
      logic fault_handler_protection_enable;
      logic enable;
   } prot_ctrl_t;
   // one data access to be checked
   typedef struct packed {
      logic valid;
      logic [31:0] addr;
      logic [1:0] size;
      logic privileged;
      logic in_fault_handler;
   } access_req_t;
   // one region as seen by the checker
   typedef struct packed {
      logic enable;
      logic [31:0] base;
      logic [4:0] size;
   } region_t;
   // bus slave states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_ACCESS = 2'b10
   } apb_state_t;
endpackage
`default_nettype wire

// ### verification/sysctl_regs_props.sv
// concurrent checks on the system control register bank ports
`timescale 1ns/100ps
`default_nettype none
module sysctl_regs_props (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire sysctl_pkg::access_req_t access,
   input wire sysctl_pkg::region_t [7:0] regions,
   input wire logic access_fault,
   input wire logic unaligned_fault,
   input wire logic exc_entry,
   input wire logic exc_return,
   input wire logic sp_misaligned,
   input wire logic [31:0] stacked_status_in,
   input wire logic [31:0] stacked_status_out,
   input wire logic sp_realign,
   input wire logic svc_pend_set,
   input wire logic svc_pending,
   input wire sysctl_pkg::prot_ctrl_t prot_ctrl
);
   logic any_en; // some region switched on
   logic mis; // access not aligned to its own size
   ////////////////////////////////////////////////////////////
   // helper logic: region summary
   always_comb begin
      any_en = 1'b0;
      for (int i = 0; i < 8; i++) begin
         any_en = any_en | regions[i].enable;
      end
   end
   assign mis = (access.size == 2'h1 && access.addr[0]) || (access.size == 2'h2 && access.addr[1:0] != 2'h0);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////
   // properties
   property p_unal;
      access.valid |=> unaligned_fault == $past(mis);
   endproperty
   a_unal: assert property (p_unal) else $error("unaligned fault wrong");
   property p_off;
      access.valid && !prot_ctrl.enable |=> !access_fault;
   endproperty
   a_off: assert property (p_off) else $error("fault while unit disabled");
   property p_nobg;
      access.valid && !mis && prot_ctrl == 3'h1 && !any_en && !access.in_fault_handler |=> access_fault;
   endproperty
   a_nobg: assert property (p_nobg) else $error("unmatched access not faulted");
   property p_bg;
      access.valid && prot_ctrl.enable && prot_ctrl.privileged_background_enable && access.privileged |=> !access_fault;
   endproperty
   a_bg: assert property (p_bg) else $error("background map refused privileged access");
   property p_hf;
      access.valid && access.in_fault_handler && !prot_ctrl.fault_handler_protection_enable |=> !access_fault;
   endproperty
   a_hf: assert property (p_hf) else $error("check active in fault handler");
   property p_entry;
      exc_entry |=> stacked_status_out[9] == $past(sp_misaligned) && stacked_status_out[31:10] == $past(stacked_status_in[31:10]);
   endproperty
   a_entry: assert property (p_entry) else $error("stacked alignment bit wrong");
   property p_ret;
      exc_return |=> sp_realign == $past(stacked_status_in[9]);
   endproperty
   a_ret: assert property (p_ret) else $error("realign not from stacked bit");
   property p_svc;
      svc_pend_set |=> svc_pending;
   endproperty
   a_svc: assert property (p_svc) else $error("supervisor call not pending");
   c_fault: cover property (access.valid ##1 access_fault);
   c_unal: cover property (access.valid ##1 unaligned_fault);
   c_svc: cover property (svc_pend_set ##1 svc_pending);
endmodule
`default_nettype wire

// ### verification/core_system_control_and_mpu_regs_bench.sv
// self-checking bench for the system control register bank
`timescale 1ns/100ps
`default_nettype none
module core_system_control_and_mpu_regs_bench;
   logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata, rd;
   sysctl_pkg::access_req_t access; // access under test
   sysctl_pkg::region_t [7:0] regions; // region set
   logic access_fault, unaligned_fault, exc_entry, exc_return, sp_misaligned, sp_realign;
   logic [31:0] stacked_status_in, stacked_status_out;
   logic svc_pend_set, svc_pend_clr, svc_pending, irq;
   logic [1:0] supervisor_call_priority, tick_exception_priority, pendable_service_priority;
   sysctl_pkg::prot_ctrl_t prot_ctrl;
   int fail_count, n_compared;
   sysctl_regs dut_u (
      .mclk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .access, .regions, .access_fault, .unaligned_fault, .exc_entry, .exc_return, .sp_misaligned,
      .stacked_status_in, .stacked_status_out, .sp_realign, .svc_pend_set, .svc_pend_clr, .svc_pending,
      .supervisor_call_priority, .tick_exception_priority, .pendable_service_priority, .prot_ctrl, .irq
   );
   ////////////////////////////////////////////////////////////
   // shared helpers
   function automatic logic [31:0] ba(input logic [15:0] o);
      return {16'he000, o};
   endfunction
   task check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one apb transfer, held until pready
   task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task settle();
      repeat (2) @(posedge mclk);
   endtask
   ////////////////////////////////////////////////////////////
   // scenarios
   task t_regs();
      logic [15:0] a [6];
      logic [31:0] r0 [6];
      logic [31:0] r1 [6];
      a = '{16'hed14, 16'hed1c, 16'hed20, 16'hed24, 16'hed90, 16'hed94};
      r0 = '{32'h208, 32'h0, 32'h0, 32'h0, 32'h800, 32'h0};
      r1 = '{32'h208, 32'hc0000000, 32'hc0c00000, 32'h8000, 32'h800, 32'h7};
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, ba(a[i]), 32'h0);
         check("reset value", r0[i], rd);
         apb(1'b1, ba(a[i]), 32'hffffffff);
         apb(1'b0, ba(a[i]), 32'h0);
         check("readback", r1[i], rd);
      end
      check("call priority", 32'h3, supervisor_call_priority);
      check("pending flag", 32'h1, svc_pending);
      check("unit control", 32'h7, prot_ctrl);
      apb(1'b1, ba(16'hed20), 32'h80400000);
      check("tick priority", 32'h2, tick_exception_priority);
      check("pendable priority", 32'h1, pendable_service_priority);
      apb(1'b1, ba(16'hed24), 32'h0);
      check("pending cleared", 32'h0, svc_pending);
   endtask
   task t_bad();
      apb(1'b1, ba(16'hed18), 32'hffffffff);
      check("unmapped write error", 32'h1, err);
      apb(1'b0, ba(16'hed18), 32'h0);
      check("unmapped read", 32'h0, rd);
      apb(1'b0, 32'h0000ed14, 32'h0);
      check("foreign page error", 32'h1, err);
      apb(1'b0, ba(16'hed14), 32'h0);
      check("config read", 32'h208, rd);
      check("mapped no error", 32'h0, err);
      check("ready", 32'h1, pready);
   endtask
   // set control, present one access, judge both faults
   task acc(input logic [2:0] c, input logic [31:0] a, input logic [1:0] s, input logic pv, input logic fh,
            input logic ef, input logic eu);
      apb(1'b1, ba(16'hed94), {29'h0, c});
      access <= '{1'b1, a, s, pv, fh};
      @(posedge mclk);
      access.valid <= 1'b0;
      #1;
      check("access fault", ef, access_fault);
      check("unaligned fault", eu, unaligned_fault);
      @(posedge mclk);
   endtask
   task t_prot();
      acc(3'h0, 32'h30000000, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0);
      acc(3'h4, 32'h30000000, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0);
      acc(3'h1, 32'h30000000, 2'h2, 1'b1, 1'b0, 1'b1, 1'b0);
      acc(3'h5, 32'h30000000, 2'h2, 1'b1, 1'b0, 1'b0, 1'b0);
      acc(3'h5, 32'h30000000, 2'h2, 1'b0, 1'b0, 1'b1, 1'b0);
      acc(3'h1, 32'h30000000, 2'h2, 1'b0, 1'b1, 1'b0, 1'b0);
      acc(3'h3, 32'h30000000, 2'h2, 1'b0, 1'b1, 1'b1, 1'b0);
      regions[0].enable <= 1'b1;
      acc(3'h1, 32'h200000fc, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0);
      acc(3'h1, 32'h20000100, 2'h2, 1'b0, 1'b0, 1'b1, 1'b0);
      acc(3'h0, 32'h30000002, 2'h2, 1'b0, 1'b0, 1'b0, 1'b1);
      acc(3'h0, 32'h30000001, 2'h1, 1'b0, 1'b0, 1'b0, 1'b1);
      acc(3'h0, 32'h30000001, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0);
   endtask
   task t_irq();
      apb(1'b0, ba(16'hedf0), 32'h0);
      check("event status", 32'h3, rd);
      apb(1'b1, ba(16'hedf4), 32'h1);
      settle();
      check("irq raised", 32'h1, irq);
      apb(1'b1, ba(16'hedf4), 32'h0);
      settle();
      check("irq masked", 32'h0, irq);
      apb(1'b1, ba(16'hedf8), 32'h3);
      apb(1'b1, ba(16'hedf4), 32'h4);
      svc_pend_set <= 1'b1;
      @(posedge mclk);
      svc_pend_set <= 1'b0;
      settle();
      check("core pending", 32'h1, svc_pending);
      check("irq on pend", 32'h1, irq);
      svc_pend_clr <= 1'b1;
      @(posedge mclk);
      svc_pend_clr <= 1'b0;
      apb(1'b1, ba(16'hedf8), 32'h4);
      settle();
      check("core cleared", 32'h0, svc_pending);
      check("irq cleared", 32'h0, irq);
      apb(1'b0, ba(16'hedf0), 32'h0);
      check("status empty", 32'h0, rd);
      apb(1'b1, ba(16'hedf0), 32'h7);
      apb(1'b0, ba(16'hedf0), 32'h0);
      check("status ignores writes", 32'h0, rd);
      apb(1'b0, ba(16'hedf8), 32'h0);
      check("clear word reads zero", 32'h0, rd);
   endtask
   task t_exc();
      sp_misaligned <= 1'b1;
      stacked_status_in <= 32'h12345000;
      exc_entry <= 1'b1;
      @(posedge mclk);
      exc_entry <= 1'b0;
      @(posedge mclk);
      check("stacked status", 32'h12345200, stacked_status_out);
      for (int i = 0; i < 2; i++) begin
         stacked_status_in <= i ? 32'hfffffdff : 32'h00000200;
         exc_return <= 1'b1;
         @(posedge mclk);
         exc_return <= 1'b0;
         @(posedge mclk);
         check("realign", i ? 32'h0 : 32'h1, sp_realign);
      end
   endtask
   // mid-run reset brings written fields back to zero
   task t_rst();
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      check("call priority after reset", 32'h0, supervisor_call_priority);
      check("tick priority after reset", 32'h0, tick_exception_priority);
      check("pendable priority after reset", 32'h0, pendable_service_priority);
      check("stacked status after reset", 32'h0, stacked_status_out);
      apb(1'b0, ba(16'hed20), 32'h0);
      check("third priority word after reset", 32'h0, rd);
   endtask
   task test_done();
      $display("comparisons %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // clock, watchdog, main sequence
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      test_done();
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {access, regions, exc_entry, exc_return, sp_misaligned, stacked_status_in} = '0;
      {svc_pend_set, svc_pend_clr, fail_count, n_compared} = '0;
      regions[0].base = 32'h20000000;
      regions[0].size = 5'h7;
      sys_rst = 1'b1;
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      t_regs();
      t_bad();
      t_prot();
      t_irq();
      t_exc();
      t_rst();
      test_done();
   end
endmodule
bind sysctl_regs sysctl_regs_props chk_u (
   .mclk, .sys_rst, .access, .regions, .access_fault, .unaligned_fault, .exc_entry, .exc_return,
   .sp_misaligned, .stacked_status_in, .stacked_status_out, .sp_realign, .svc_pend_set, .svc_pending, .prot_ctrl
);
`default_nettype wire
